/* timer_channel_defines.vh */
// Register map, field positions and reset values of the timer channel block.
`ifndef TIMER_CHANNEL_DEFINES_VH
`define TIMER_CHANNEL_DEFINES_VH

// ==========================================================================
// Register byte addresses
// ==========================================================================
`define CTRL_BASE        8'h00
`define CTRL_STRIDE      8'h04
`define VALUE_HI_BASE    8'h10
`define VALUE_LO_BASE    8'h14
`define VALUE_STRIDE     8'h08
`define IRQ_STATUS_ADDR  8'h30
`define IRQ_MASK_ADDR    8'h34

// ==========================================================================
// Channel control register fields
// ==========================================================================
`define FULL_DUTY_BIT    0
`define TOGGLE_WRAP_BIT  1
`define ELS_LO_BIT       2
`define ELS_HI_BIT       3
`define COMPARE_MODE_BIT 4
`define BUFFERED_BIT     5
`define EVENT_FLAG_BIT   7
`define CTRL_WIDTH       6
`define CTRL_RESET       6'h00
`define CTRL_MASK_EVEN   6'h3f
`define CTRL_MASK_ODD    6'h1f

// ==========================================================================
// Edge/level select encodings
// ==========================================================================
`define ELS_OFF          2'b00
`define ELS_TOGGLE       2'b01
`define ELS_CLEAR        2'b10
`define ELS_SET          2'b11
`define ELS_RISE         2'b01
`define ELS_FALL         2'b10

`define OUT_LEVEL_RESET  1'b1
`define MASK_RESET       4'h0

`endif

/* channel_edge_detect.v */
// Pin synchroniser and rising/falling edge detector for one channel input.
module channel_edge_detect (
    input  wire clk_sys,
    input  wire reset,
    input  wire pinAsync,
    output wire rise,
    output wire fall
);

    reg syncFirst;
    reg syncSecond;
    reg previous;

    // The first stage feeds only the second; edges are judged downstream.
    always @(posedge clk_sys) begin
        if (reset) begin
            syncFirst  <= 1'b0;
            syncSecond <= 1'b0;
            previous   <= 1'b0;
        end else begin
            syncFirst  <= pinAsync;
            syncSecond <= syncFirst;
            previous   <= syncSecond;
        end
    end

    assign rise = syncSecond & ~previous;
    assign fall = ~syncSecond & previous;

endmodule

/* timer_channel_mode_logic.v */
// Four-channel capture/compare/PWM mode logic with an APB register slave.
//
// Chosen here: the register addresses and the APB interface to the registers.
`include "timer_channel_defines.vh"

// Overview of operation
// - Capture mode: edge bits 01 rising, 10 falling, 11 either edge.
// - Edge bits 00: port owns pin; mode bit A presets level, 0 high.
// - Channel drives pin only while edge/level bits are nonzero.
// - Unbuffered compare: 00 software only, 01 toggle, 10 clear, 11 set.
// - Buffered compare: 01 toggle, 10 clear, 11 set on match.
// - Reset clears edge/level bits of every channel.
// - Toggle-on-wrap toggles compare output at each overflow; capture ignores.
// - Overflow toggle wins over a coincident compare action.
// - Full-duty bit with toggle and clear selected forces 100 percent.
// - Full-duty changes apply from the period after the write.
// - Sixteen-bit value register, byte access, holds capture or compare.
// - Capture mode: high byte read blocks captures until low byte read.
// - Compare mode: high byte write blocks matches until low byte write, except to the odd register of a buffered pair.
// - Match or active edge sets channel flag; enabled flag interrupts.
// - Buffered mode on channel 0 or 2 disables the next channel.
module timer_channel_mode_logic #(
    parameter CHANNELS = 4,
    parameter CNT_W    = 16
) (
    input  wire                clk_sys,
    input  wire                reset,
    input  wire [7:0]          paddr,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    input  wire [CNT_W-1:0]    counterValue,
    input  wire                counterWrap,
    input  wire [CHANNELS-1:0] channelPinIn,
    output wire [CHANNELS-1:0] channelPinOut,
    output wire [CHANNELS-1:0] channelPinOe,
    output wire                irq
);

    // ======================================================================
    // Bus decode
    // ======================================================================
    wire accessWr = psel & penable & pwrite;
    wire accessRd = psel & penable & ~pwrite;
    wire setupRd  = psel & ~penable & ~pwrite;

    reg  [CHANNELS-1:0]         irqMask;
    wire [CHANNELS-1:0]         eventFlag;
    wire [CHANNELS-1:0]         bufferedSel;
    wire [CHANNELS*CNT_W-1:0]   valueFlat;
    wire [CHANNELS-1:0]         compareBlockFlat;
    wire [CHANNELS*8-1:0]       ctrlReadFlat;
    wire [CHANNELS-1:0]         hitFlat;

    wire statusHit = (paddr == `IRQ_STATUS_ADDR);
    wire maskHit   = (paddr == `IRQ_MASK_ADDR);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(|hitFlat | statusHit | maskHit);
    assign irq     = |(eventFlag & irqMask);

    always @(posedge clk_sys) begin
        if (reset) begin
            irqMask <= `MASK_RESET;
        end else if (accessWr && maskHit) begin
            irqMask <= pwdata[CHANNELS-1:0];
        end
    end

    // ======================================================================
    // Channels
    // ======================================================================
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : chan
            localparam integer CTRL_A = `CTRL_BASE + `CTRL_STRIDE * i;
            localparam integer HI_A   = `VALUE_HI_BASE + `VALUE_STRIDE * i;
            localparam integer LO_A   = `VALUE_LO_BASE + `VALUE_STRIDE * i;
            localparam integer LO_N   = `VALUE_LO_BASE + `VALUE_STRIDE * (i+1);
            localparam IS_EVEN = ((i % 2) == 0);

            reg [`CTRL_WIDTH-1:0] ctrl;
            reg [CNT_W-1:0]       value;
            reg                   flag;
            reg                   outLevel;
            reg                   fullDutyLive;
            reg                   captureBlock;
            reg                   compareBlock;
            reg                   pendingSel;
            reg                   activeSel;
            wire                  disabled;
            wire                  rise;
            wire                  fall;

            if (IS_EVEN) begin : evenSide
                assign disabled = 1'b0;
            end else begin : oddSide
                assign disabled = bufferedSel[i-1];
            end

            wire [`CTRL_WIDTH-1:0] ctrlEff =
                disabled ? `CTRL_RESET : ctrl;
            wire [1:0] els = {ctrlEff[`ELS_HI_BIT], ctrlEff[`ELS_LO_BIT]};
            wire msA       = ctrlEff[`COMPARE_MODE_BIT];
            wire msB       = ctrlEff[`BUFFERED_BIT];
            wire toggleOn  = ctrlEff[`TOGGLE_WRAP_BIT];
            wire captureMode = ~msB & ~msA;
            wire captureOn   = captureMode & (els != `ELS_OFF);
            wire compareOn   = msB | msA;
            wire clearSel    = (els == `ELS_CLEAR);
            wire forceFull   = fullDutyLive & toggleOn & clearSel;

            wire ctrlWr = accessWr && (paddr == CTRL_A[7:0]);
            wire hiWr   = accessWr && (paddr == HI_A[7:0]);
            wire loWr   = accessWr && (paddr == LO_A[7:0]);
            wire hiRd   = accessRd && (paddr == HI_A[7:0]);
            wire loRd   = accessRd && (paddr == LO_A[7:0]);
            wire nextLoWr;
            if (IS_EVEN && (i + 1 < CHANNELS)) begin : pairWr
                assign nextLoWr = accessWr && (paddr == LO_N[7:0]);
            end else begin : noPairWr
                assign nextLoWr = 1'b0;
            end

            assign hitFlat[i] = (paddr == CTRL_A[7:0]) ||
                                (paddr == HI_A[7:0]) ||
                                (paddr == LO_A[7:0]);

            channel_edge_detect edgeDetect (
                .clk_sys  (clk_sys),
                .reset    (reset),
                .pinAsync (channelPinIn[i]),
                .rise     (rise),
                .fall     (fall)
            );

            // Active edge selection in capture mode.
            wire edgeHit = (els == `ELS_RISE) ? rise :
                           (els == `ELS_FALL) ? fall :
                           (rise | fall);
            wire capture = captureOn & edgeHit & ~captureBlock;

            // Buffered pairs compare against the register chosen at wrap.
            wire [CNT_W-1:0] compareValue;
            wire             compareHeld;
            if (IS_EVEN && (i + 1 < CHANNELS)) begin : pairCmp
                assign compareValue = (msB && activeSel) ?
                    valueFlat[(i+1)*CNT_W +: CNT_W] : value;
                assign compareHeld = (msB && activeSel) ?
                    compareBlockFlat[i+1] : compareBlock;
            end else begin : singleCmp
                assign compareValue = value;
                assign compareHeld  = compareBlock;
            end

            wire match = compareOn & ~compareHeld &
                         (counterValue == compareValue);

            always @(posedge clk_sys) begin
                if (reset) begin
                    ctrl         <= `CTRL_RESET;
                    flag         <= 1'b0;
                    outLevel     <= `OUT_LEVEL_RESET;
                    fullDutyLive <= 1'b0;
                    captureBlock <= 1'b0;
                    compareBlock <= 1'b0;
                    pendingSel   <= 1'b0;
                    activeSel    <= 1'b0;
                end else begin
                    if (ctrlWr && !disabled) begin
                        ctrl <= pwdata[`CTRL_WIDTH-1:0] &
                            (IS_EVEN ? `CTRL_MASK_EVEN : `CTRL_MASK_ODD);
                    end
                    // A new event wins over a clear in the same cycle.
                    if (capture || match) begin
                        flag <= 1'b1;
                    end else if (accessWr && statusHit && pwdata[i]) begin
                        flag <= 1'b0;
                    end
                    if (loRd) begin
                        captureBlock <= 1'b0;
                    end else if (hiRd && captureMode) begin
                        captureBlock <= 1'b1;
                    end
                    if (loWr) begin
                        compareBlock <= 1'b0;
                    end else if (hiWr && !captureMode) begin
                        compareBlock <= 1'b1;
                    end
                    if (loWr) begin
                        pendingSel <= 1'b0;
                    end else if (nextLoWr) begin
                        pendingSel <= 1'b1;
                    end
                    if (counterWrap) begin
                        activeSel    <= pendingSel;
                        fullDutyLive <= ctrlEff[`FULL_DUTY_BIT];
                    end
                    if (els == `ELS_OFF) begin
                        outLevel <= ~msA;
                    end else if (compareOn) begin
                        if (counterWrap && toggleOn) begin
                            // Overflow beats a coincident match.
                            outLevel <= forceFull ? 1'b1 : ~outLevel;
                        end else if (match && !forceFull) begin
                            case (els)
                                `ELS_TOGGLE: outLevel <= ~outLevel;
                                `ELS_CLEAR:  outLevel <= 1'b0;
                                `ELS_SET:    outLevel <= 1'b1;
                                default:     outLevel <= outLevel;
                            endcase
                        end
                    end
                end
            end

            // The value register is deliberately left out of reset.
            always @(posedge clk_sys) begin
                if (capture) begin
                    value <= counterValue;
                end else begin
                    if (hiWr) begin
                        value[CNT_W-1:8] <= pwdata[CNT_W-9:0];
                    end
                    if (loWr) begin
                        value[7:0] <= pwdata[7:0];
                    end
                end
            end

            assign eventFlag[i]        = flag;
            assign bufferedSel[i]      = msB;
            assign compareBlockFlat[i] = compareBlock;
            assign valueFlat[i*CNT_W +: CNT_W] = value;
            // A disabled odd channel reads as an empty register.
            assign ctrlReadFlat[i*8 +: 8] =
                disabled ? 8'h00 : {flag, 1'b0, ctrlEff};
            assign channelPinOut[i] = outLevel;
            assign channelPinOe[i]  = (els != `ELS_OFF);
        end
    endgenerate

    // ======================================================================
    // Read data
    // ======================================================================
    // Read data is captured in the setup cycle so the access phase ends at
    // once; a capture landing in that single cycle is seen on the next read.
    reg [31:0] next_prdata;
    integer    k;

    always @* begin
        next_prdata = 32'h00000000;
        for (k = 0; k < CHANNELS; k = k + 1) begin
            if (paddr == `CTRL_BASE + `CTRL_STRIDE * k[7:0]) begin
                next_prdata[7:0] = ctrlReadFlat[k*8 +: 8];
            end
            if (paddr == `VALUE_HI_BASE + `VALUE_STRIDE * k[7:0]) begin
                next_prdata[7:0] = valueFlat[k*CNT_W+8 +: 8];
            end
            if (paddr == `VALUE_LO_BASE + `VALUE_STRIDE * k[7:0]) begin
                next_prdata[7:0] = valueFlat[k*CNT_W +: 8];
            end
        end
        if (statusHit) begin
            next_prdata[CHANNELS-1:0] = eventFlag;
        end
        if (maskHit) begin
            next_prdata[CHANNELS-1:0] = irqMask;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (setupRd) begin
            prdata <= next_prdata;
        end
    end

endmodule

/* timer_channel_mode_logic_properties.sv */
// Port-level assertions for the timer channel mode logic.
module timer_channel_mode_logic_properties #(
    parameter CHANNELS = 4,
    parameter CNT_W    = 16
) (
    input wire                clk_sys,
    input wire                reset,
    input wire [7:0]          paddr,
    input wire                psel,
    input wire                penable,
    input wire                pwrite,
    input wire [31:0]         pwdata,
    input wire [31:0]         prdata,
    input wire                pready,
    input wire                pslverr,
    input wire [CNT_W-1:0]    counterValue,
    input wire                counterWrap,
    input wire [CHANNELS-1:0] channelPinIn,
    input wire [CHANNELS-1:0] channelPinOut,
    input wire [CHANNELS-1:0] channelPinOe,
    input wire                irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lastWrite;
    always @(posedge clk_sys) lastWrite <= psel && penable && pwrite;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_access; psel && penable; endsequence
    sequence s_unmapped; psel && penable && paddr > 8'h37; endsequence
    a_ready_high: assert property (s_access |-> pready)
        else $error("pready low in access");
    a_unmapped_err: assert property (s_unmapped |-> pslverr)
        else $error("no error on unmapped address");
    a_err_access_only: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    a_unmapped_zero: assert property (s_unmapped ##0 !pwrite |->
        prdata == 32'h0) else $error("unmapped read not zero");
    a_reset_oe: assert property (disable iff (1'b0)
        reset |=> channelPinOe == '0) else $error("pin owned after reset");
    a_reset_level: assert property (disable iff (1'b0)
        reset |=> channelPinOut == '1) else $error("preset level not high");
    a_oe_cause: assert property (!$stable(channelPinOe) &&
        !$past(reset) |-> lastWrite) else $error("pin ownership moved alone");
    a_irq_fall: assert property ($fell(irq) && !$past(reset)
        |-> lastWrite) else $error("interrupt dropped without a write");
endmodule

/* channel_pin_driver.sv */
// Outside circuit that drives the four channel input pins.
module channel_pin_driver (
    input  wire logic  clk_sys,
    output logic [3:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pinLevel = 4'h0;
    // A level moves just after an edge and then holds, so the capture
    // synchroniser never sees a pin that settles late.
    task automatic drive(input int ch, input logic lvl, input int hold);
        pinLevel[ch] <= lvl;
        repeat (hold) @(posedge clk_sys);
    endtask
endmodule

/* timer_channel_mode_logic_tb.sv */
// Self-checking bench for the timer channel mode logic.
`include "timer_channel_defines.vh"
module timer_channel_mode_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, reset, psel, penable, pwrite, counterWrap;
    logic        pready, pslverr, irq, lastErr, lvl;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] counterValue, cv, cmp, cmp2;
    logic [3:0]  pinLevel, channelPinOut, channelPinOe;
    logic [1:0]  els;
    logic [5:0]  cmpModes [7] = '{6'h1c, 6'h14, 6'h14, 6'h1c, 6'h14,
                                  6'h18, 6'h10};
    logic [5:0]  bufModes [3] = '{6'h24, 6'h2c, 6'h28};
    int          fail_count = 0;
    int          samples_checked = 0;
    int          seed = 95;
    timer_channel_mode_logic u_dut (.clk_sys(clk_sys), .reset(reset),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counterValue(counterValue),
        .counterWrap(counterWrap), .channelPinIn(pinLevel),
        .channelPinOut(channelPinOut), .channelPinOe(channelPinOe),
        .irq(irq));
    channel_pin_driver u_pins (.clk_sys(clk_sys), .pinLevel(pinLevel));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // ======================================================================
    // Bus and check helpers
    // ======================================================================
    function logic [7:0] ctl(input int ch);
        return 8'(`CTRL_BASE + `CTRL_STRIDE * ch);
    endfunction
    function logic expLevel(input logic [1:0] e, input logic o);
        return (e == `ELS_TOGGLE) ? !o : (e == `ELS_OFF) ? o : e[0];
    endfunction
    task check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task print_verdict;
        $display("mismatches %0d checks %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task wrv(input int ch, input logic [15:0] v);
        apb(1'b1, 8'(`VALUE_HI_BASE + `VALUE_STRIDE * ch), {24'h0, v[15:8]});
        apb(1'b1, 8'(`VALUE_LO_BASE + `VALUE_STRIDE * ch), {24'h0, v[7:0]});
    endtask
    task rdv(input int ch, output logic [15:0] v);
        apb(1'b0, 8'(`VALUE_HI_BASE + `VALUE_STRIDE * ch), 32'h0);
        v[15:8] = rd[7:0];
        apb(1'b0, 8'(`VALUE_LO_BASE + `VALUE_STRIDE * ch), 32'h0);
        v[7:0] = rd[7:0];
    endtask
    task pulse(input logic [15:0] v, input logic w);
        counterValue <= v;
        counterWrap <= w;
        @(posedge clk_sys);
        counterValue <= 16'h0;
        counterWrap <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Compare on ch0: set the mode, fire one match, check pin and owner.
    task cmpStep(input logic [5:0] c, input logic [15:0] v);
        apb(1'b1, ctl(0), {26'h0, c});
        lvl = channelPinOut[0];
        pulse(v, 1'b0);
        check("pin level", channelPinOut[0], expLevel(c[3:2], lvl));
        check("pin owner", channelPinOe[0], c[3:2] != 2'b00);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        print_verdict;
    end
    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        {reset, psel, penable, pwrite, counterWrap} = 5'b10000;
        {paddr, pwdata, counterValue} = '0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        check("owner", channelPinOe, 4'h0);
        check("level", channelPinOut, 4'hf);
        for (int c = 0; c < 4; c++) begin
            apb(1'b0, ctl(c), 32'h0);
            check("ctrl", rd, 32'h0);
            cv = 16'($random(seed));
            wrv(c, cv);
            rdv(c, cmp);
            check("value", cmp, cv);
        end
        apb(1'b0, 8'h3c, 32'h0);
        check("unmapped err", lastErr, 1'b1);
        check("unmapped data", rd, 32'h0);
        for (int k = 1; k < 4; k++) begin
            els = 2'(k);
            apb(1'b1, ctl(1), {28'h0, els, 2'b00});
            for (int j = 0; j < 2; j++) begin
                apb(1'b1, `IRQ_STATUS_ADDR, 32'hf);
                cv = 16'($random(seed)) | 16'h8000;
                counterValue <= cv;
                u_pins.drive(1, ~pinLevel[1], 4);
                apb(1'b0, `IRQ_STATUS_ADDR, 32'h0);
                check("capture flag", rd[1], els[j]);
                rdv(1, cmp);
                if (els[j]) check("captured", cmp, cv);
            end
        end
        apb(1'b0, 8'(`VALUE_HI_BASE + `VALUE_STRIDE), 32'h0);
        counterValue <= ~cv;
        u_pins.drive(1, 1'b1, 4);
        rdv(1, cmp);
        check("held capture", cmp, cv);
        apb(1'b1, ctl(1), 32'h6);
        lvl = channelPinOut[1];
        pulse(16'h0, 1'b1);
        check("capture wrap", channelPinOut[1], lvl);
        cmp = 16'($random(seed)) & 16'h7ffe | 16'h0001;
        wrv(0, cmp);
        foreach (cmpModes[n]) cmpStep(cmpModes[n], cmp);
        apb(1'b1, `IRQ_MASK_ADDR, 32'h1);
        check("irq set", irq, 1'b1);
        apb(1'b1, `IRQ_STATUS_ADDR, 32'h1);
        check("irq clear", irq, 1'b0);
        cmp2 = cmp ^ 16'h0300;
        apb(1'b1, ctl(0), 32'h14);
        apb(1'b1, 8'(`VALUE_HI_BASE), {24'h0, cmp2[15:8]});
        lvl = channelPinOut[0];
        pulse({cmp2[15:8], cmp[7:0]}, 1'b0);
        check("match blocked", channelPinOut[0], lvl);
        apb(1'b0, `IRQ_STATUS_ADDR, 32'h0);
        check("blocked flag", rd[0], 1'b0);
        apb(1'b1, 8'(`VALUE_LO_BASE), {24'h0, cmp2[7:0]});
        cmpStep(6'h14, cmp2);
        apb(1'b1, ctl(0), 32'h1e);
        for (int j = 0; j < 2; j++) begin
            lvl = channelPinOut[0];
            pulse(cmp2, 1'b1);
            check("wrap wins", channelPinOut[0], !lvl);
        end
        cmpStep(6'h1b, cmp2);
        pulse(16'h0, 1'b1);
        check("full duty wrap", channelPinOut[0], 1'b1);
        pulse(cmp2, 1'b0);
        check("full duty", channelPinOut[0], 1'b1);
        check("full duty owner", channelPinOe[0], 1'b1);
        apb(1'b1, ctl(0), 32'h1a);
        pulse(cmp2, 1'b0);
        check("full duty held", channelPinOut[0], 1'b1);
        pulse(16'h0, 1'b1);
        pulse(cmp2, 1'b0);
        check("full duty off", channelPinOut[0], 1'b0);
        apb(1'b1, ctl(0), 32'h24);
        apb(1'b1, ctl(1), 32'h0c);
        check("odd owner", channelPinOe[1], 1'b0);
        apb(1'b0, ctl(1), 32'h0);
        check("odd ctrl", rd, 32'h0);
        foreach (bufModes[n]) begin
            apb(1'b1, ctl(0), {26'h0, bufModes[n]});
            lvl = channelPinOut[0];
            pulse(cmp2, 1'b0);
            els = bufModes[n][3:2];
            check("buffered", channelPinOut[0], expLevel(els, lvl));
        end
        apb(1'b1, ctl(0), 32'h24);
        wrv(1, cmp);
        lvl = channelPinOut[0];
        pulse(cmp, 1'b0);
        check("source kept", channelPinOut[0], lvl);
        pulse(16'h0, 1'b1);
        pulse(cmp, 1'b0);
        check("source swapped", channelPinOut[0], !lvl);
        print_verdict;
    end
endmodule
bind timer_channel_mode_logic timer_channel_mode_logic_properties #(
    .CHANNELS(CHANNELS), .CNT_W(CNT_W)) u_props (.clk_sys(clk_sys),
    .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counterValue(counterValue),
    .counterWrap(counterWrap), .channelPinIn(channelPinIn),
    .channelPinOut(channelPinOut), .channelPinOe(channelPinOe), .irq(irq));
